// *** logic/nbw_block_write.sv ***
// write sequencer for the nonvolatile array unit with page buffer
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps

// Behaviour
// - array unit has 64 sectors, each 32 pages plus one spare page
// - page holds 8 blocks of 16 bytes plus a 4-byte side segment
// - address: sector 17:12, page 11:7, block 6:4, byte 3:0
// - reserved row select ignores address 11:7, picks the sector's spare page
// - side segment select ignores address 6:2, picks the side segment
// - sector 0 spare page: writes fail with error, reads return zero
// - busy is clocked; operations are taken only while busy is low
// - write to a page not buffered holds busy 55 cycles for the copy
// - copy: per block 5 read cycles, 1 write cycle, then 1 reload
// - writes to the last written block of the buffered page add no busy
// - other block of buffered page: busy 4 cycles, 5 with pipelining
// - status 00 means success, non-zero means error and no write
// - status holds its value until the next write is taken; reads leave it
// - one word per write request, sized by word size select
// - writes go anywhere in any order; partial buffer is fine
// - write to overwrite protected sector is refused with status 01
// - page loss protection refuses writes to other pages, status 11
module nbw_block_write (
   input  wire logic                         aclk,
   input  wire logic                         aresetn,
   input  wire logic                         wr_req,
   input  wire logic                         rd_req,
   input  wire logic [nbw_pkg::ADDR_W-1:0]   wr_addr,
   input  wire logic [31:0]                  wr_data,
   input  wire logic [1:0]                   word_size_select,
   input  wire logic                         reserved_row_select,
   input  wire logic                         side_segment_select,
   output logic                              busy_q,
   output logic [1:0]                        status_q,
   output logic                              rd_valid_q,
   output logic [31:0]                       rd_data_q,
   output logic                              arr_rd_req_q,
   output logic [nbw_pkg::TAG_W-1:0]         arr_rd_page_q,
   output logic [nbw_pkg::BIDX_W-1:0]        arr_rd_blk_q,
   input  wire logic [nbw_pkg::BLK_DW-1:0]   arr_rd_data,
   input  wire logic [nbw_pkg::AXI_AW-1:0]   s_axi_awaddr,
   input  wire logic                         s_axi_awvalid,
   output logic                              s_axi_awready,
   input  wire logic [31:0]                  s_axi_wdata,
   input  wire logic [3:0]                   s_axi_wstrb,
   input  wire logic                         s_axi_wvalid,
   output logic                              s_axi_wready,
   output logic [1:0]                        s_axi_bresp,
   output logic                              s_axi_bvalid,
   input  wire logic                         s_axi_bready,
   input  wire logic [nbw_pkg::AXI_AW-1:0]   s_axi_araddr,
   input  wire logic                         s_axi_arvalid,
   output logic                              s_axi_arready,
   output logic [31:0]                       s_axi_rdata,
   output logic [1:0]                        s_axi_rresp,
   output logic                              s_axi_rvalid,
   input  wire logic                         s_axi_rready
);
   import nbw_pkg::*;

   // ==========================================================
   // helpers
   // sector and spare page
   function automatic logic [TAG_W-1:0] tag_of(input logic [ADDR_W-1:0] a, input logic spare);
      // spare page keeps a zero page field so all its aliases match
      tag_of = {a[SEC_LSB +: SEC_W], spare, spare ? {PG_W{1'b0}} : a[PG_LSB +: PG_W]};
   endfunction : tag_of

   function automatic logic [BIDX_W-1:0] blk_of(input logic [ADDR_W-1:0] a, input logic aux);
      blk_of = aux ? AUX_BLK : {1'b0, a[BLK_LSB +: 3]};
   endfunction : blk_of

   function automatic logic [BYTE_W-1:0] byte_of(input logic [ADDR_W-1:0] a, input logic aux);
      byte_of = aux ? {2'h0, a[1:0]} : a[BYTE_W-1:0];
   endfunction : byte_of

   function automatic logic [31:0] strb_merge(input logic [31:0] o, input logic [31:0] n,
                                              input logic [3:0] s);
      for (int i = 0; i < 4; i++) begin
         strb_merge[8*i +: 8] = s[i] ? n[8*i +: 8] : o[8*i +: 8];
      end
   endfunction : strb_merge

   // ==========================================================
   // state
   nbw_state_e            st_q;
   logic [2:0]            cnt_q;
   logic [BIDX_W-1:0]     blk_q;
   logic [BLK_DW-1:0]     blk_reg_q;
   logic                  buf_valid_q;
   logic [TAG_W-1:0]      buf_tag_q;
   logic [BIDX_W-1:0]     cur_blk_q;
   logic [BIDX_W-1:0]     pend_blk_q;
   logic [BLK_BYTES-1:0]  pend_be_q;
   logic [BLK_DW-1:0]     pend_data_q;
   logic [1:0]            ctrl_q;
   logic [31:0]           prot_lo_q;
   logic [31:0]           prot_hi_q;
   logic                  drop_q;
   logic                  rp_v_q;
   logic                  rp_zero_q;
   logic [1:0]            rp_wsel_q;
   nbw_pb_if              pb ();

   nbw_page_mem u_mem (
      .aclk (aclk),
      .p    (pb.mem)
   );

   // ==========================================================
   // request decode
   // field split
   wire [TAG_W-1:0]     w_tag   = tag_of(wr_addr, reserved_row_select);
   wire                 w_spare = reserved_row_select;
   wire [BIDX_W-1:0]    w_blk   = blk_of(wr_addr, side_segment_select);
   wire [BYTE_W-1:0]    w_byt   = byte_of(wr_addr, side_segment_select);
   wire [SEC_W-1:0]     w_sec   = wr_addr[SEC_LSB +: SEC_W];
   wire [63:0]          prot_v  = {prot_hi_q, prot_lo_q};
   wire                 wr_take = wr_req && !busy_q;
   wire                 rd_take = rd_req && !busy_q && !wr_req;
   wire                 buf_ok  = buf_valid_q && !drop_q;
   wire                 w_hit   = buf_ok && (w_tag == buf_tag_q);
   wire                 w_sp0   = w_spare && (w_sec == '0);
   wire                 w_prot  = prot_v[w_sec];
   wire                 w_loss  = ctrl_q[CTRL_PLP] && buf_ok && !w_hit;
   wire [1:0]           w_err   = w_sp0 ? ST_SPARE0 : w_prot ? ST_PROT : w_loss ? ST_LOSS : ST_OK;
   wire                 w_ok    = (w_err == ST_OK);
   wire [BLK_BYTES-1:0] w_be    = (word_size_select == WS_BYTE) ? 16'h0001 << w_byt :
                                  (word_size_select == WS_HALF) ? 16'h0003 << {w_byt[3:1], 1'b0} :
                                                                  16'h000F << {w_byt[3:2], 2'h0};
   wire [BLK_DW-1:0]    w_data  = (word_size_select == WS_BYTE) ? {16{wr_data[7:0]}} :
                                  (word_size_select == WS_HALF) ? {8{wr_data[15:0]}} :
                                                                  {4{wr_data}};
   wire [TAG_W-1:0]     r_tag   = tag_of(wr_addr, reserved_row_select);
   wire [BYTE_W-1:0]    r_byt   = byte_of(wr_addr, side_segment_select);
   wire                 r_zero  = !(buf_ok && r_tag == buf_tag_q) || w_sp0;

   // ==========================================================
   // page buffer port
   wire cwr = (st_q == S_CWR);
   wire rel = (st_q == S_RELOAD);
   wire imm = wr_take && w_ok && w_hit;
   assign pb.we    = cwr || rel || imm;
   assign pb.wblk  = cwr ? blk_q : rel ? pend_blk_q : w_blk;
   assign pb.wbe   = cwr ? {BLK_BYTES{1'b1}} : rel ? pend_be_q : w_be;
   assign pb.wdata = cwr ? blk_reg_q : rel ? pend_data_q : w_data;
   assign pb.re    = rd_take || rel;
   assign pb.rblk  = rel ? pend_blk_q : blk_of(wr_addr, side_segment_select);

   // ==========================================================
   // write sequencer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= S_IDLE;
         cnt_q <= '0;
         blk_q <= '0;
         busy_q <= 1'b0;
         status_q <= ST_OK;
         buf_valid_q <= 1'b0;
         buf_tag_q <= '0;
         cur_blk_q <= '0;
         arr_rd_req_q <= 1'b0;
         arr_rd_page_q <= '0;
         arr_rd_blk_q <= '0;
         pend_blk_q <= '0;
         pend_be_q <= '0;
         pend_data_q <= '0;
         blk_reg_q <= '0;
      end else begin
         if (drop_q) begin
            buf_valid_q <= 1'b0;
         end
         unique case (st_q)
            S_IDLE: if (wr_take) begin
               status_q <= w_err;
               if (w_ok && w_hit && w_blk != cur_blk_q) begin
                  busy_q <= 1'b1;
                  cnt_q <= ctrl_q[CTRL_PIPE] ? SWP_LAST : SW_LAST;
                  cur_blk_q <= w_blk;
                  st_q <= S_SWITCH;
               end else if (w_ok && !w_hit) begin
                  busy_q <= 1'b1;
                  buf_valid_q <= 1'b0;
                  buf_tag_q <= w_tag;
                  pend_blk_q <= w_blk;
                  pend_be_q <= w_be;
                  pend_data_q <= w_data;
                  blk_q <= '0;
                  cnt_q <= '0;
                  arr_rd_req_q <= 1'b1;
                  arr_rd_page_q <= w_tag;
                  arr_rd_blk_q <= '0;
                  st_q <= S_CRD;
               end
            end
            S_CRD: begin
               arr_rd_req_q <= 1'b0;
               cnt_q <= cnt_q + 3'h1;
               if (cnt_q == RD_LAST) begin
                  blk_reg_q <= arr_rd_data;
                  st_q <= S_CWR;
               end
            end
            S_CWR: begin
               cnt_q <= '0;
               if (blk_q == LAST_BLK) begin
                  st_q <= S_RELOAD;
               end else begin
                  blk_q <= blk_q + 4'h1;
                  arr_rd_req_q <= 1'b1;
                  arr_rd_blk_q <= blk_q + 4'h1;
                  st_q <= S_CRD;
               end
            end
            // pending word stored at the same edge that busy drops
            S_RELOAD: begin
               busy_q <= 1'b0;
               status_q <= ST_OK;
               buf_valid_q <= 1'b1;
               cur_blk_q <= pend_blk_q;
               st_q <= S_IDLE;
            end
            S_SWITCH: begin
               cnt_q <= cnt_q - 3'h1;
               if (cnt_q == '0) begin
                  busy_q <= 1'b0;
                  st_q <= S_IDLE;
               end
            end
         endcase
      end
   end

   // ==========================================================
   // user read path, two cycle latency
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rp_v_q <= 1'b0;
         rp_zero_q <= 1'b0;
         rp_wsel_q <= '0;
         rd_valid_q <= 1'b0;
         rd_data_q <= '0;
      end else begin
         rp_v_q <= rd_take;
         rp_zero_q <= r_zero;
         rp_wsel_q <= r_byt[3:2];
         rd_valid_q <= rp_v_q;
         // zero for pages not in the buffer and for sector 0 spare page
         if (rp_v_q) begin
            rd_data_q <= rp_zero_q ? 32'h0000_0000 : pb.rdata[32*rp_wsel_q +: 32];
         end
      end
   end

   // ==========================================================
   // register slave
   wire aw_hs  = s_axi_awvalid && s_axi_awready;
   wire w_hs   = s_axi_wvalid && s_axi_wready;
   wire aw_hav = !s_axi_awready || aw_hs;
   wire w_hav  = !s_axi_wready || w_hs;
   logic [AXI_AW-1:0] awaddr_q;
   logic [31:0]       wdat_q;
   logic [3:0]        wstrb_q;
   wire [AXI_AW-1:0]  wa    = aw_hs ? s_axi_awaddr : awaddr_q;
   wire [31:0]        wd    = w_hs ? s_axi_wdata : wdat_q;
   wire [3:0]         ws    = w_hs ? s_axi_wstrb : wstrb_q;
   wire               do_wr = aw_hav && w_hav && !s_axi_bvalid;
   wire               wmap  = wa == OFS_CTRL || wa == OFS_PROT_LO || wa == OFS_PROT_HI || wa == OFS_STAT;
   wire [31:0]        stat_v = {12'h000, buf_tag_q, cur_blk_q, buf_valid_q, busy_q, status_q};
   wire [31:0]        rmux  = (s_axi_araddr == OFS_CTRL)    ? {30'h0, ctrl_q} :
                              (s_axi_araddr == OFS_PROT_LO) ? prot_lo_q :
                              (s_axi_araddr == OFS_PROT_HI) ? prot_hi_q :
                              (s_axi_araddr == OFS_STAT)    ? stat_v : 32'h0000_0000;
   wire               rmap  = s_axi_araddr == OFS_CTRL || s_axi_araddr == OFS_PROT_LO ||
                              s_axi_araddr == OFS_PROT_HI || s_axi_araddr == OFS_STAT;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         awaddr_q <= '0;
         wdat_q <= '0;
         wstrb_q <= '0;
         ctrl_q <= CTRL_RST;
         prot_lo_q <= PROT_RST;
         prot_hi_q <= PROT_RST;
         drop_q <= 1'b0;
      end else begin
         drop_q <= 1'b0;
         if (aw_hs) begin
            awaddr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (w_hs) begin
            wdat_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (do_wr) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wmap ? RESP_OKAY : RESP_SLVERR;
            if (wa == OFS_CTRL && ws[0]) begin
               ctrl_q <= wd[1:0];
               drop_q <= wd[CTRL_DROP];
            end
            if (wa == OFS_PROT_LO) begin
               prot_lo_q <= strb_merge(prot_lo_q, wd, ws);
            end
            if (wa == OFS_PROT_HI) begin
               prot_hi_q <= strb_merge(prot_hi_q, wd, ws);
            end
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rmux;
         s_axi_rresp <= rmap ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end
endmodule : nbw_block_write

// *** shared/nbw_pkg.sv ***
// constants and types shared by the nonvolatile block write interface
package nbw_pkg;
   // ==========================================================
   // array organisation and address fields
   localparam int ADDR_W     = 18;
   localparam int SEC_W      = 6;
   localparam int PG_W       = 5;
   localparam int BYTE_W     = 4;
   localparam int SEC_LSB    = 12;
   localparam int PG_LSB     = 7;
   localparam int BLK_LSB    = 4;
   localparam int N_SECTORS  = 64;
   localparam int N_PAGES    = 32;
   localparam int N_BLKS     = 9;
   localparam int BLK_BYTES  = 16;
   localparam int AUX_BYTES  = 4;
   localparam int BIDX_W     = 4;
   localparam int TAG_W      = SEC_W + 1 + PG_W;
   localparam int BLK_DW     = 8 * BLK_BYTES;
   localparam logic [BIDX_W-1:0] AUX_BLK = 4'h8;
   localparam logic [BIDX_W-1:0] LAST_BLK = 4'h8;
   // ==========================================================
   // copy and block switch timing, in cycles
   localparam int RD_CYC     = 5;
   localparam int WR_CYC     = 1;
   localparam int RELOAD_CYC = 1;
   localparam int COPY_CYC   = N_BLKS * (RD_CYC + WR_CYC) + RELOAD_CYC;
   localparam logic [2:0] RD_LAST  = 3'(RD_CYC - 1);
   localparam logic [2:0] SW_LAST  = 3'h3;
   localparam logic [2:0] SWP_LAST = 3'h4;
   // ==========================================================
   // word sizes and status codes
   localparam logic [1:0] WS_BYTE   = 2'h0;
   localparam logic [1:0] WS_HALF   = 2'h1;
   localparam logic [1:0] ST_OK     = 2'h0;
   localparam logic [1:0] ST_PROT   = 2'h1;
   localparam logic [1:0] ST_SPARE0 = 2'h2;
   localparam logic [1:0] ST_LOSS   = 2'h3;
   // ==========================================================
   // register map
   localparam int AXI_AW = 8;
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_PROT_LO = 8'h04;
   localparam logic [7:0] OFS_PROT_HI = 8'h08;
   localparam logic [7:0] OFS_STAT    = 8'h0C;
   localparam int CTRL_PIPE = 0;
   localparam int CTRL_PLP  = 1;
   localparam int CTRL_DROP = 2;
   localparam logic [1:0]  CTRL_RST = 2'h0;
   localparam logic [31:0] PROT_RST = 32'h0;
   localparam int STAT_BUSY = 2;
   localparam int STAT_BUFV = 3;
   localparam int STAT_CBLK = 4;
   localparam int STAT_TAG  = 8;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {S_IDLE, S_CRD, S_CWR, S_RELOAD, S_SWITCH} nbw_state_e;
endpackage : nbw_pkg

// *** shared/nbw_pb_if.sv ***
// page buffer port between the sequencer and its memory
`timescale 1ns/100ps
interface nbw_pb_if;
   import nbw_pkg::*;
   logic                we;
   logic [BIDX_W-1:0]   wblk;
   logic [BLK_BYTES-1:0] wbe;
   logic [BLK_DW-1:0]   wdata;
   logic                re;
   logic [BIDX_W-1:0]   rblk;
   logic [BLK_DW-1:0]   rdata;
   modport ctrl (output we, wblk, wbe, wdata, re, rblk, input rdata);
   modport mem  (input we, wblk, wbe, wdata, re, rblk, output rdata);
endinterface : nbw_pb_if

// *** logic/nbw_page_mem.sv ***
// page buffer memory: nine blocks, byte enables, registered read
`timescale 1ns/100ps
module nbw_page_mem (
   input wire logic aclk,
   nbw_pb_if.mem    p
);
   import nbw_pkg::*;

   // ==========================================================
   // byte lanes, each its own array so no two processes share one
   for (genvar i = 0; i < BLK_BYTES; i++) begin : g_lane
      logic [7:0] lane_q [N_BLKS];
      always_ff @(posedge aclk) begin
         if (p.we && p.wbe[i]) begin
            lane_q[p.wblk] <= p.wdata[8*i +: 8];
         end
         if (p.re) begin
            p.rdata[8*i +: 8] <= lane_q[p.rblk];
         end
      end
   end
endmodule : nbw_page_mem

// *** testbench/nbw_block_write_asserts.sv ***
// concurrent checks on the block write sequencer ports
`timescale 1ns/100ps
module nbw_block_write_asserts (
   input wire logic                      aclk,
   input wire logic                      aresetn,
   input wire logic                      wr_req,
   input wire logic                      rd_req,
   input wire logic                      busy_q,
   input wire logic [1:0]                status_q,
   input wire logic                      rd_valid_q,
   input wire logic                      arr_rd_req_q,
   input wire logic [nbw_pkg::BIDX_W-1:0] arr_rd_blk_q
);
   import nbw_pkg::*;
   logic [5:0] busy_cnt_q;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ==========================================================
   // busy run length, cleared whenever busy is low
   always_ff @(posedge aclk) begin
      if (!aresetn || !busy_q) busy_cnt_q <= 6'h00;
      else busy_cnt_q <= busy_cnt_q + 6'h01;
   end
   // ==========================================================
   // checks
   busy_take_a: assert property ($rose(busy_q) |-> $past(wr_req) && !$past(busy_q))
      else $error("busy rose without a taken write");
   busy_len_a: assert property ($fell(busy_q) && $past(aresetn) |-> busy_cnt_q inside {6'h04, 6'h05, 6'h37})
      else $error("busy run length wrong");
   copy_done_a: assert property ($fell(busy_q) && busy_cnt_q == 6'h37 |-> status_q == ST_OK)
      else $error("status not ok when copy ended");
   copy_first_a: assert property ($rose(busy_q) && arr_rd_req_q |-> arr_rd_blk_q == 4'h0)
      else $error("copy did not start at block zero");
   blk_gap_a: assert property (arr_rd_req_q |=> !arr_rd_req_q [*5])
      else $error("block reads closer than six cycles");
   blk_step_a: assert property (arr_rd_req_q && arr_rd_blk_q != LAST_BLK |->
      ##6 arr_rd_req_q && arr_rd_blk_q == $past(arr_rd_blk_q, 6) + 4'h1)
      else $error("next block read not six cycles later");
   blk_last_a: assert property (arr_rd_req_q && arr_rd_blk_q == LAST_BLK |-> busy_q [*7] ##1 !busy_q)
      else $error("copy tail length wrong");
   status_hold_a: assert property ($past(aresetn) && !($past(wr_req) && !$past(busy_q)) && !$fell(busy_q)
      |-> $stable(status_q))
      else $error("status changed without a new write");
   rd_answer_a: assert property (rd_req && !wr_req && !busy_q |-> ##2 rd_valid_q)
      else $error("read answer missing");
endmodule : nbw_block_write_asserts

bind nbw_block_write nbw_block_write_asserts u_nbw_block_write_asserts (
   .aclk(aclk), .aresetn(aresetn), .wr_req(wr_req), .rd_req(rd_req), .busy_q(busy_q),
   .status_q(status_q), .rd_valid_q(rd_valid_q), .arr_rd_req_q(arr_rd_req_q), .arr_rd_blk_q(arr_rd_blk_q)
);

// *** testbench/nbw_array_model.sv ***
// behavioural model of the nonvolatile array answering block reads
`timescale 1ns/100ps
module nbw_array_model (
   input  wire logic [0:0]                  aclk,
   input  wire logic                        arr_rd_req_q,
   input  wire logic [nbw_pkg::TAG_W-1:0]   arr_rd_page_q,
   input  wire logic [nbw_pkg::BIDX_W-1:0]  arr_rd_blk_q,
   output logic [nbw_pkg::BLK_DW-1:0]       arr_rd_data
);
   import nbw_pkg::*;
   logic [2:0]  hold_q;
   logic [31:0] word_q;
   // data held over the five-cycle read window
   // outside the window the word toggles so a late capture shows
   always_ff @(posedge aclk) begin
      if (arr_rd_req_q) begin
         word_q <= {arr_rd_page_q, arr_rd_blk_q, 16'h5AC3};
         hold_q <= 3'h5;
      end else if (hold_q != 3'h0) begin
         hold_q <= hold_q - 3'h1;
      end else begin
         word_q <= ~word_q;
      end
   end
   assign arr_rd_data = {4{word_q}};
endmodule : nbw_array_model

// *** testbench/test_nbw_block_write.sv ***
// self-checking bench for the block write sequencer
`timescale 1ns/100ps
module test_nbw_block_write;
   import nbw_pkg::*;
   logic aclk = 1'b0, aresetn = 1'b0, wr_req = 1'b0, rd_req = 1'b0;
   logic reserved_row_select = 1'b0, side_segment_select = 1'b0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [ADDR_W-1:0] wr_addr = 18'h0;
   logic [31:0]       wr_data = 32'h0, s_axi_wdata = 32'h0, rd_data_q, s_axi_rdata;
   logic [1:0]        word_size_select = 2'h2, status_q, s_axi_bresp, s_axi_rresp;
   logic [AXI_AW-1:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
   logic [3:0]        s_axi_wstrb = 4'hF;
   logic busy_q, rd_valid_q, arr_rd_req_q, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [TAG_W-1:0]  arr_rd_page_q;
   logic [BIDX_W-1:0] arr_rd_blk_q;
   logic [BLK_DW-1:0] arr_rd_data;
   logic [11:0]       tg;
   int fails = 0, tests_run = 0, cyc = 0;

   nbw_block_write u_nbw_block_write (.aclk, .aresetn, .wr_req, .rd_req, .wr_addr, .wr_data, .word_size_select,
      .reserved_row_select, .side_segment_select, .busy_q, .status_q, .rd_valid_q, .rd_data_q, .arr_rd_req_q,
      .arr_rd_page_q, .arr_rd_blk_q, .arr_rd_data, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   nbw_array_model u_nbw_array_model (.aclk, .arr_rd_req_q, .arr_rd_page_q, .arr_rd_blk_q, .arr_rd_data);

   always #2.5 aclk = ~aclk;
   // ==========================================================
   // tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   // busy is sampled at each edge, so the count is the busy cycles after the take
   task automatic wr(input logic [17:0] a, input logic [31:0] d, input logic [1:0] ws, input logic sp,
                     input logic ax, input logic [1:0] st, input int nb);
      int n;
      n = 0;
      wr_addr <= a;
      wr_data <= d;
      word_size_select <= ws;
      reserved_row_select <= sp;
      side_segment_select <= ax;
      wr_req <= 1'b1;
      @(posedge aclk);
      wr_req <= 1'b0;
      do begin
         @(posedge aclk);
         n++;
      end while (busy_q !== 1'b0 && n < 100);
      check(32'(n - 1), 32'(nb));
      check(32'(status_q), 32'(st));
   endtask : wr
   task automatic rd(input logic [17:0] a, input logic sp, input logic ax, input logic [31:0] exp);
      int n;
      n = 0;
      wr_addr <= a;
      reserved_row_select <= sp;
      side_segment_select <= ax;
      rd_req <= 1'b1;
      @(posedge aclk);
      rd_req <= 1'b0;
      do begin
         @(posedge aclk);
         n++;
      end while (rd_valid_q !== 1'b1 && n < 8);
      check(32'(rd_valid_q), 32'h1);
      check(rd_data_q, exp);
   endtask : rd
   // one register access; for a read, d is the expected word
   task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
      int n;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= w;
      s_axi_wvalid <= w;
      s_axi_bready <= w;
      s_axi_arvalid <= !w;
      s_axi_rready <= !w;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while ((w ? s_axi_bvalid : s_axi_rvalid) !== 1'b1 && n < 50);
      s_axi_bready <= 1'b0;
      s_axi_rready <= 1'b0;
      check(32'(w ? s_axi_bvalid : s_axi_rvalid), 32'h1);
      check(32'(w ? s_axi_bresp : s_axi_rresp), 32'(resp));
      if (!w) check(s_axi_rdata, d);
      @(posedge aclk);
   endtask : axi
   task automatic stop_test;
      if (fails == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : stop_test
   // ==========================================================
   // hang guard: the sequence needs well under 2000 cycles
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fails++;
         stop_test();
      end
   end
   // ==========================================================
   // sequence
   initial begin
      tg = {6'h01, 1'b0, 5'h03};
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      check(32'({busy_q, status_q}), 32'h0);
      axi(0, OFS_STAT, 32'h0, RESP_OKAY);
      axi(0, OFS_PROT_HI, PROT_RST, RESP_OKAY);
      wr({6'h01, 5'h03, 3'h2, 4'h4}, 32'h11223344, 2'h2, 0, 0, ST_OK, 55);
      axi(0, OFS_STAT, {12'h0, tg, 4'h2, 4'h8}, RESP_OKAY);
      rd({6'h01, 5'h03, 3'h2, 4'h4}, 0, 0, 32'h11223344);
      rd({6'h01, 5'h03, 3'h5, 4'hC}, 0, 0, {tg, 4'h5, 16'h5AC3});
      rd({6'h01, 5'h03, 3'h0, 4'h0}, 0, 1, {tg, 4'h8, 16'h5AC3});
      wr({6'h01, 5'h03, 3'h2, 4'h8}, 32'hA5A50001, 2'h2, 0, 0, ST_OK, 0);
      wr({6'h01, 5'h03, 3'h6, 4'h5}, 32'h000000EE, WS_BYTE, 0, 0, ST_OK, 4);
      rd({6'h01, 5'h03, 3'h6, 4'h4}, 0, 0, {tg, 4'h6, 8'hEE, 8'hC3});
      axi(1, OFS_CTRL, 32'h1, RESP_OKAY);
      wr({6'h01, 5'h03, 3'h5, 4'hC}, 32'hCAFE0008, 2'h2, 0, 1, ST_OK, 5);
      rd({6'h01, 5'h03, 3'h0, 4'h0}, 0, 1, 32'hCAFE0008);
      axi(1, OFS_PROT_LO, 32'h2, RESP_OKAY);
      wr({6'h01, 5'h03, 3'h2, 4'h4}, 32'h99999999, 2'h2, 0, 0, ST_PROT, 0);
      rd({6'h01, 5'h03, 3'h2, 4'h4}, 0, 0, 32'h11223344);
      check(32'(status_q), 32'(ST_PROT));
      axi(1, OFS_PROT_LO, 32'h3, RESP_OKAY);
      wr({6'h00, 5'h04, 3'h1, 4'h0}, 32'h12345678, 2'h2, 1, 0, ST_SPARE0, 0);
      rd({6'h00, 5'h00, 3'h1, 4'h0}, 1, 0, 32'h0);
      axi(1, OFS_PROT_LO, 32'h0, RESP_OKAY);
      axi(1, OFS_CTRL, 32'h3, RESP_OKAY);
      axi(0, OFS_CTRL, 32'h3, RESP_OKAY);
      wr({6'h02, 5'h00, 3'h0, 4'h0}, 32'h77777777, 2'h2, 0, 0, ST_LOSS, 0);
      wr({6'h01, 5'h03, 3'h3, 4'h0}, 32'h33333333, 2'h2, 0, 0, ST_OK, 5);
      axi(1, OFS_CTRL, 32'h0, RESP_OKAY);
      wr({6'h03, 5'h07, 3'h1, 4'h0}, 32'h5151A0A0, 2'h2, 1, 0, ST_OK, 55);
      rd({6'h03, 5'h1A, 3'h1, 4'h0}, 1, 0, 32'h5151A0A0);
      rd({6'h03, 5'h00, 3'h4, 4'h0}, 1, 0, {6'h03, 1'b1, 5'h00, 4'h4, 16'h5AC3});
      rd({6'h01, 5'h03, 3'h2, 4'h4}, 0, 0, 32'h0);
      axi(1, 8'h10, 32'hFFFFFFFF, RESP_SLVERR);
      axi(0, 8'h10, 32'h0, RESP_SLVERR);
      axi(0, OFS_CTRL, 32'h0, RESP_OKAY);
      axi(1, OFS_CTRL, 32'h4, RESP_OKAY);
      wr({6'h03, 5'h00, 3'h1, 4'h0}, 32'h0A0B0C0D, 2'h2, 1, 0, ST_OK, 55);
      stop_test();
   end
endmodule : test_nbw_block_write
